// ===== inc/dio_map.svh
// Purpose: Register offsets, field positions and reset values of the digital I/O block
// Assumes: Byte addresses on a 32-bit classic Wishbone bus, one register per word
// Notes:   Definitions only
`ifndef DIO_MAP_SVH
`define DIO_MAP_SVH

`define DIO_ADR_W        6
`define DIO_PORT_CNT     6
`define DIO_REG_PORT0    6'h00
`define DIO_REG_PORT5    6'h14
`define DIO_REG_DIR      6'h18
`define DIO_REG_TCTRL    6'h1C
`define DIO_REG_RELOAD0  6'h20
`define DIO_REG_RELOAD1  6'h24
`define DIO_REG_RELOAD2  6'h28
`define DIO_REG_INT_EN   6'h2C
`define DIO_REG_INT_FLAG 6'h30
`define DIO_REG_STRAPS   6'h34
`define DIO_DIR_RST      8'h00
`define DIO_OUT_RST      48'h000000000000
`define DIO_RELOAD_RST   16'hFFFF
`define DIO_INT_CNT      6
`define DIO_G0_C0_BIT    16
`define DIO_G0_C4_BIT    20
`define DIO_G1_C0_BIT    40
`define DIO_G1_C4_BIT    44

`endif

// ===== inc/dio_pkg.sv
// Purpose: Shared types of the digital I/O block
// Assumes: Constants live in dio_map.svh
// Notes:   Types only
package dio_pkg;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [5:0]  adr;
    logic [31:0] dat;
  } wb_req_t;

  // Direction straps of one group, high means forced output
  typedef struct packed {
    logic c_high;
    logic c_low;
    logic b;
    logic a;
  } dir_straps_t;

endpackage

// ===== rtl/dio_ports.sv
// Purpose: Six 8-bit digital I/O ports with warm reset retention, timers and interrupt mirror
// Assumes: All pins and straps synchronous to clk_i; pullups outside hold idle inputs high
// Notes:   Wishbone slave answers every access one cycle after the request
`timescale 1ns/100ps
`default_nettype none
`include "dio_map.svh"

// What this block does
// - Forty-eight I/O lines as six 8-bit ports, three per group.
// - Software sets each port's direction when its strap allows it.
// - Ports are plain latched outputs or direct inputs, no handshake.
// - Each c port has separate low and high nibble direction straps.
// - After reset software ports are inputs unless retention keeps them.
// - A strap-forced output ignores software requests to become input.
// - After reset strap-forced outputs drive zero unless retention keeps them.
// - With retention on, warm reset keeps direction and output values.
// - Retention covers software ports and strap-forced ports alike.
// - Power-on reset always clears retained state to defaults.
// - With retention off, any reset restores input and low defaults.
// - Timers 0, 1 and counter 2 choose external pin or internal clock.
// - Timer 1 internal clock is timer 0 output, forming 32 bits.
// - Of the two 16-bit timers only timer 1 raises an interrupt on expiry.
// - The 16-bit event counter raises an event interrupt.
// - Interrupts come only from c bits 0 and 4, timer 1, counter 2.
// - A connector pin copies the interrupt at the same moment.
// - Mirror pin goes high on interrupt, low when it is cleared.
module dio_ports #(
  parameter int unsigned TW      = 16,   // Timer width
  parameter int unsigned INT_DIV = 200   // Clock cycles per internal timer tick
) (
  input  wire logic                 clk_i,          // 200 MHz clock
  input  wire logic                 rst_i,          // Warm reset, sync, high
  input  wire logic                 por_i,          // Power-on reset, sync, high
  input  wire dio_pkg::wb_req_t     wb_i,           // Wishbone request
  output logic [31:0]               wb_dat_o,       // Wishbone read data
  output logic                      wb_ack_o,       // Wishbone acknowledge
  input  wire logic [47:0]          port_in_i,      // Pin levels
  output logic [47:0]               port_out_o,     // Pin drive values
  output logic [47:0]               port_oe_o,      // Pin output enables
  input  wire dio_pkg::dir_straps_t group0_straps_i, // Group 0 direction straps
  input  wire dio_pkg::dir_straps_t group1_straps_i, // Group 1 direction straps
  input  wire logic                 warm_reset_retain_strap_i,   // Keep state on warm reset
  input  wire logic                 timer0_clock_select_strap_i, // High selects internal
  input  wire logic                 timer1_clock_select_strap_i, // High selects timer 0 out
  input  wire logic                 counter2_clock_select_strap_i, // High selects internal
  input  wire logic [2:0]           ext_clk_i,      // External timer clock pins
  output logic [2:0]                timer_out_o,    // Timer expiry pulses
  output logic                      irq_o,          // Interrupt to the host
  output logic                      int_mirror_o    // Interrupt copy on the connector
);

  // Direction control bit of one nibble: bit 4g+0 a, 4g+1 b, 4g+2/3 c halves
  function automatic logic nib_ctl(input logic [7:0] bits, input int unsigned n);
    int unsigned port;
    int unsigned k;
    port = n / 2;
    k    = port % 3;
    if (k < 2) begin
      nib_ctl = bits[(port / 3) * 4 + k];
    end else begin
      nib_ctl = bits[(port / 3) * 4 + 2 + (n % 2)];
    end
  endfunction

  localparam logic [7:0] DIV_MAX = 8'(INT_DIV - 1);

  logic [7:0]           straps;
  logic [7:0]           dir_q, dir_d;
  logic [47:0]          out_q, out_d;
  logic [47:0]          oe_d;
  logic                 port_rst, all_rst;
  logic                 req, wr, rd_req;
  logic [3:0]           tctrl_q;
  logic [TW-1:0]        reload_q [3];
  logic [TW-1:0]        cnt_q [3];
  logic [2:0]           exp_q, tick, int_src_sel, ext_q, ext_rise;
  logic [7:0]           div_q;
  logic                 div_tick;
  logic [3:0]           cin_q;
  logic [3:0]           cin_rise;
  logic [5:0]           int_en_q, flag_q, flag_d, flag_clr, int_src;
  logic [31:0]          rd_data;
  logic [31:0]          wmask;
  logic [2:0]           port_idx;
  logic                 port_hit;

  // Strap and reset decode
  assign straps   = {group1_straps_i, group0_straps_i};
  assign port_rst = por_i | (rst_i & ~warm_reset_retain_strap_i);
  assign all_rst  = por_i | rst_i;

  // Bus decode; writes land on the edge where ack is seen high
  assign req      = wb_i.cyc & wb_i.stb;
  assign rd_req   = req & ~wb_ack_o;
  assign wr       = req & wb_i.we & wb_ack_o;
  assign wmask    = {{8{wb_i.sel[3]}}, {8{wb_i.sel[2]}}, {8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};
  assign port_hit = (wb_i.adr <= `DIO_REG_PORT5) && (wb_i.adr[1:0] == 2'b00);
  assign port_idx = wb_i.adr[4:2];

  // Next direction: software bits only, straps override at the pin
  assign dir_d = port_rst ? `DIO_DIR_RST :
                 (wr && wb_i.adr == `DIO_REG_DIR && wb_i.sel[0]) ? wb_i.dat[7:0] : dir_q;

  // Output latches and enables per nibble
  genvar n;
  generate
    for (n = 0; n < 12; n++) begin : g_nib
      logic wr_nib;
      assign wr_nib = wr && port_hit && (port_idx == 3'(n / 2)) && wb_i.sel[0];
      assign out_d[n*4 +: 4] = port_rst ? 4'(`DIO_OUT_RST >> (n*4)) :
                               wr_nib ? wb_i.dat[(n%2)*4 +: 4] : out_q[n*4 +: 4];
      assign oe_d[n*4 +: 4]  = {4{nib_ctl(straps, n) | nib_ctl(dir_d, n)}};
    end
  endgenerate

  // Port state registers; enables follow straps even during reset
  always_ff @(posedge clk_i) begin
    dir_q     <= dir_d;
    out_q     <= out_d;
    port_oe_o <= oe_d;
  end

  assign port_out_o = out_q;

  // Internal time base shared by timer 0 and counter 2
  assign div_tick = (div_q == DIV_MAX);
  always_ff @(posedge clk_i) begin
    if (all_rst) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_tick ? 8'h00 : div_q + 8'h01;
    end
  end

  // Clock source selection
  assign int_src_sel = {counter2_clock_select_strap_i, timer1_clock_select_strap_i,
                        timer0_clock_select_strap_i};
  assign ext_rise    = ext_clk_i & ~ext_q;
  assign tick[0]     = int_src_sel[0] ? div_tick : ext_rise[0];
  assign tick[1]     = int_src_sel[1] ? exp_q[0] : ext_rise[1];
  assign tick[2]     = int_src_sel[2] ? div_tick : ext_rise[2];

  // Down counters reload and pulse on reaching the end of count
  genvar t;
  generate
    for (t = 0; t < 3; t++) begin : g_tmr
      logic last;
      assign last = (cnt_q[t] <= TW'(1));
      always_ff @(posedge clk_i) begin
        if (all_rst) begin
          cnt_q[t] <= `DIO_RELOAD_RST;
          exp_q[t] <= 1'b0;
        end else if (!tctrl_q[t]) begin
          cnt_q[t] <= reload_q[t];
          exp_q[t] <= 1'b0;
        end else begin
          exp_q[t] <= tick[t] & last;
          if (tick[t]) begin
            cnt_q[t] <= last ? reload_q[t] : cnt_q[t] - TW'(1);
          end
        end
      end
    end
  endgenerate

  // Timer control and reload registers
  always_ff @(posedge clk_i) begin
    if (all_rst) begin
      tctrl_q     <= 4'h0;
      reload_q[0] <= `DIO_RELOAD_RST;
      reload_q[1] <= `DIO_RELOAD_RST;
      reload_q[2] <= `DIO_RELOAD_RST;
      int_en_q    <= 6'h00;
    end else if (wr) begin
      case (wb_i.adr)
        `DIO_REG_TCTRL:   tctrl_q     <= (wb_i.dat[3:0] & wmask[3:0]) | (tctrl_q & ~wmask[3:0]);
        `DIO_REG_RELOAD0: reload_q[0] <= (wb_i.dat[TW-1:0] & wmask[TW-1:0]) |
                                         (reload_q[0] & ~wmask[TW-1:0]);
        `DIO_REG_RELOAD1: reload_q[1] <= (wb_i.dat[TW-1:0] & wmask[TW-1:0]) |
                                         (reload_q[1] & ~wmask[TW-1:0]);
        `DIO_REG_RELOAD2: reload_q[2] <= (wb_i.dat[TW-1:0] & wmask[TW-1:0]) |
                                         (reload_q[2] & ~wmask[TW-1:0]);
        `DIO_REG_INT_EN:  int_en_q    <= (wb_i.dat[5:0] & wmask[5:0]) | (int_en_q & ~wmask[5:0]);
        default:          tctrl_q     <= tctrl_q;
      endcase
    end
  end

  // Interrupt sources: rising edges on c bits 0 and 4, timer 1, counter 2
  assign cin_rise = {port_in_i[`DIO_G1_C4_BIT], port_in_i[`DIO_G1_C0_BIT],
                     port_in_i[`DIO_G0_C4_BIT], port_in_i[`DIO_G0_C0_BIT]} & ~cin_q;
  assign int_src  = {exp_q[2], exp_q[1], cin_rise};
  assign flag_clr = (wr && wb_i.adr == `DIO_REG_INT_FLAG) ? (wb_i.dat[5:0] & wmask[5:0]) : 6'h00;
  assign flag_d   = (flag_q & ~flag_clr) | int_src;                          // Set beats clear

  // Edge history, sticky flags and interrupt outputs
  always_ff @(posedge clk_i) begin
    if (all_rst) begin
      ext_q        <= 3'h0;
      cin_q        <= 4'hF;
      flag_q       <= 6'h00;
      irq_o        <= 1'b0;
      int_mirror_o <= 1'b0;
      timer_out_o  <= 3'h0;
    end else begin
      ext_q        <= ext_clk_i;
      cin_q        <= {port_in_i[`DIO_G1_C4_BIT], port_in_i[`DIO_G1_C0_BIT],
                       port_in_i[`DIO_G0_C4_BIT], port_in_i[`DIO_G0_C0_BIT]};
      flag_q       <= flag_d;
      irq_o        <= |(flag_d & int_en_q);
      int_mirror_o <= |(flag_d & int_en_q);
      timer_out_o  <= exp_q;
    end
  end

  // Read mux; output ports read back their latch, inputs read the pins
  always_comb begin
    rd_data = 32'h00000000;
    if (port_hit) begin
      for (int i = 0; i < `DIO_PORT_CNT; i++) begin
        if (port_idx == 3'(i)) begin
          rd_data[7:0] = (port_oe_o[i*8 +: 8] & out_q[i*8 +: 8]) |
                         (~port_oe_o[i*8 +: 8] & port_in_i[i*8 +: 8]);
        end
      end
    end else begin
      case (wb_i.adr)
        `DIO_REG_DIR:      rd_data[7:0]    = dir_q | straps;
        `DIO_REG_TCTRL:    rd_data[3:0]    = tctrl_q;
        `DIO_REG_RELOAD0:  rd_data[TW-1:0] = reload_q[0];
        `DIO_REG_RELOAD1:  rd_data[TW-1:0] = reload_q[1];
        `DIO_REG_RELOAD2:  rd_data[TW-1:0] = reload_q[2];
        `DIO_REG_INT_EN:   rd_data[5:0]    = int_en_q;
        `DIO_REG_INT_FLAG: rd_data[5:0]    = flag_q;
        `DIO_REG_STRAPS:   rd_data[11:0]   = {int_src_sel, warm_reset_retain_strap_i, straps};
        default:           rd_data         = 32'h00000000;
      endcase
    end
  end

  // Bus answer: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (all_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= rd_req;
      wb_dat_o <= rd_req ? rd_data : wb_dat_o;
    end
  end

endmodule
`default_nettype wire

// ===== tb/dio_ports_props.sv
// Purpose: Bus, reset, strap and interrupt properties of dio_ports
// Assumes: Straps change only while a reset is held
// Notes:   Attached by the bind below the module
`timescale 1ns/100ps
`default_nettype none
module dio_ports_props (
  input wire logic                 clk_i,                     // Clock
  input wire logic                 rst_i,                     // Warm reset
  input wire logic                 por_i,                     // Power-on reset
  input wire dio_pkg::wb_req_t     wb_i,                      // Bus request
  input wire logic                 wb_ack_o,                  // Bus acknowledge
  input wire logic [47:0]          port_out_o,                // Pin drive values
  input wire logic [47:0]          port_oe_o,                 // Pin enables
  input wire dio_pkg::dir_straps_t group0_straps_i,           // Group 0 straps
  input wire dio_pkg::dir_straps_t group1_straps_i,           // Group 1 straps
  input wire logic                 warm_reset_retain_strap_i, // Retention
  input wire logic [2:0]           timer_out_o,               // Expiry pulses
  input wire logic                 irq_o,                     // Host interrupt
  input wire logic                 int_mirror_o               // Connector copy
);
  logic [47:0] smask;
  // Enables that the straps alone force high
  assign smask = {{4{group1_straps_i.c_high}}, {4{group1_straps_i.c_low}},
                  {8{group1_straps_i.b}}, {8{group1_straps_i.a}},
                  {4{group0_straps_i.c_high}}, {4{group0_straps_i.c_low}},
                  {8{group0_straps_i.b}}, {8{group0_straps_i.a}}};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || por_i);
  ack_one_a: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("no acknowledge one cycle after request");
  ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  mirror_copy_a: assert property (int_mirror_o == irq_o)
    else $error("mirror pin differs from interrupt");
  strap_out_a: assert property (group0_straps_i.a |-> &port_oe_o[7:0])
    else $error("forced port not driving");
  nibble_strap_a: assert property (group1_straps_i.c_low |-> &port_oe_o[43:40])
    else $error("forced low nibble not driving");
  reset_default_a: assert property (disable iff (1'b0)
    por_i || (rst_i && !warm_reset_retain_strap_i) |=> port_out_o == 48'h0 && port_oe_o == smask)
    else $error("reset did not restore defaults");
  warm_keep_a: assert property (disable iff (por_i)
    rst_i && warm_reset_retain_strap_i |=> $stable(port_out_o) && $stable(port_oe_o))
    else $error("warm reset disturbed ports");
  tmr_pulse_a: assert property (timer_out_o[1] |=> !timer_out_o[1])
    else $error("timer pulse longer than one cycle");
  cover property (rst_i && warm_reset_retain_strap_i);
  cover property ($rose(irq_o));
  cover property (timer_out_o[1]);
endmodule
bind dio_ports dio_ports_props props_i (.*);
`default_nettype wire

// ===== tb/field_dev.sv
// Purpose: Field devices on the digital connector
// Assumes: Every pin has a pull-up
// Notes:   The bench chooses which pins a device drives
`timescale 1ns/100ps
`default_nettype none
module field_dev (
  input  wire logic [47:0] out_i,     // Block drive values
  input  wire logic [47:0] oe_i,      // Block enables
  input  wire logic [47:0] ext_en_i,  // Device drives pin
  input  wire logic [47:0] ext_val_i, // Device level
  output logic      [47:0] pin_o      // Level on each pin
);
  // Block wins where it drives, else a device, else the pull-up
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i) | (~oe_i & ~ext_en_i);
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Purpose: Self-checking bench for dio_ports
// Assumes: Pull-ups on all pins, internal timer clocks
// Notes:   Internal tick shortened to 4 cycles
`timescale 1ns/100ps
`default_nettype none
`include "dio_map.svh"
module tb;
  logic clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, warm_reset_retain_strap_i = 1'b0;
  logic timer0_clock_select_strap_i = 1'b1, timer1_clock_select_strap_i = 1'b1;
  logic counter2_clock_select_strap_i = 1'b1;
  logic [2:0] ext_clk_i = 3'h0;
  dio_pkg::wb_req_t wb_i = '0;
  dio_pkg::dir_straps_t group0_straps_i = 4'h1, group1_straps_i = 4'h2;
  logic [47:0] ext_en = 48'h0, ext_val = 48'h0, port_in_i, port_out_o, port_oe_o;
  logic [31:0] wb_dat_o, rd;
  logic [2:0]  timer_out_o;
  logic        wb_ack_o, irq_o, int_mirror_o;
  int          err_count = 0, check_count = 0;
  dio_ports #(.INT_DIV(4)) uut (.*);
  field_dev fd (.out_i(port_out_o), .oe_i(port_oe_o), .ext_en_i(ext_en),
                .ext_val_i(ext_val), .pin_o(port_in_i));
  // Clock and watchdog
  initial forever #2.5 clk_i = ~clk_i;
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    end_of_test();
  end
  function automatic logic [47:0] sm();
    return {{4{group1_straps_i.c_high}}, {4{group1_straps_i.c_low}}, {8{group1_straps_i.b}},
            {8{group1_straps_i.a}}, 16'h0000, {8{group0_straps_i.a}}};
  endfunction
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_i <= '{1'b1, 1'b1, w, 4'hF, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_i <= '0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk({16'h0000, rd}, {16'h0000, e});
  endtask
  task automatic rs(input logic p);
    if (p) por_i <= 1'b1;
    else rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    por_i <= 1'b0;
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wirq();
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic arm();
    wb(1'b1, `DIO_REG_DIR, 32'h02);
    wb(1'b1, 6'h04, 32'hA5);
    wb(1'b1, `DIO_REG_PORT0, 32'h3C);
  endtask
  task automatic t_defaults();
    for (int i = 0; i < 2; i++) begin
      group1_straps_i <= (i == 0) ? 4'hD : 4'h2;
      rs(1'b1);
      chk(port_oe_o, sm());
      chk(port_out_o, 48'h0);
    end
    rdc(6'h04, 32'hFF);
  endtask
  task automatic t_dir();
    arm();
    rdc(6'h04, 32'hA5);
    chk(port_oe_o, sm() | 48'hFF00);
    chk(port_out_o, 48'hA53C);
    wb(1'b1, `DIO_REG_DIR, 32'h00);
    rdc(`DIO_REG_DIR, 32'h21);
    chk(port_oe_o, sm());
  endtask
  task automatic t_keep();
    arm();
    warm_reset_retain_strap_i <= 1'b1;
    rs(1'b0);
    chk(port_out_o, 48'hA53C);
    chk(port_oe_o, sm() | 48'hFF00);
    rs(1'b1);
    chk(port_out_o | port_oe_o, sm());
    arm();
    warm_reset_retain_strap_i <= 1'b0;
    rs(1'b0);
    chk(port_out_o | port_oe_o, sm());
  endtask
  task automatic t_irq();
    wb(1'b1, `DIO_REG_INT_EN, 32'h31);
    ext_en <= 48'h000000010100;
    repeat (4) @(posedge clk_i);
    ext_val <= 48'h000000000100;
    repeat (4) @(posedge clk_i);
    rdc(`DIO_REG_INT_FLAG, 32'h00);
    ext_val <= 48'h000000010100;
    repeat (4) @(posedge clk_i);
    rdc(`DIO_REG_INT_FLAG, 32'h01);
    chk(48'({irq_o, int_mirror_o}), 48'h3);
    wb(1'b1, `DIO_REG_INT_FLAG, 32'h01);
    chk(48'({irq_o, int_mirror_o}), 48'h0);
  endtask
  task automatic t_tmr();
    wb(1'b1, `DIO_REG_RELOAD0, 32'h2);
    wb(1'b1, `DIO_REG_RELOAD1, 32'h2);
    wb(1'b1, `DIO_REG_RELOAD2, 32'h2);
    wb(1'b1, `DIO_REG_INT_EN, 32'h10);
    wb(1'b1, `DIO_REG_TCTRL, 32'h3);
    wirq();
    wb(1'b1, `DIO_REG_TCTRL, 32'h4);
    rdc(`DIO_REG_INT_FLAG, 32'h10);
    wb(1'b1, `DIO_REG_INT_FLAG, 32'h10);
    wb(1'b1, `DIO_REG_INT_EN, 32'h20);
    wirq();
    wb(1'b1, `DIO_REG_TCTRL, 32'h0);
    rdc(`DIO_REG_INT_FLAG, 32'h20);
    wb(1'b1, `DIO_REG_INT_FLAG, 32'h3F);
    chk(48'({irq_o, int_mirror_o}), 48'h0);
  endtask
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    por_i <= 1'b0;
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_defaults();
    t_dir();
    t_keep();
    t_irq();
    t_tmr();
    end_of_test();
  end
endmodule
`default_nettype wire
